// file: mctl_params.svh
// Constants of the PROM and I/O bus configuration and error block.
`ifndef MCTL_PARAMS_SVH
`define MCTL_PARAMS_SVH
`define CFG1_OFF     8'h00
`define CFG2_OFF     8'h04
`define CFG3_OFF     8'h08
`define CFG4_OFF     8'h0c
`define PROM_READY_ENABLE_BIT    30
`define ASYNC_READY_ENABLE_BIT    29
`define IOW_HI       28
`define IOW_LO       27
`define IO_READY_ENABLE_BIT    26
`define BEXC_BIT     25
`define IOWS_HI      23
`define IOWS_LO      20
`define IO_AREA_ENABLE_BIT     19
`define BANK_HI      17
`define BANK_LO      14
`define PROM_WRITE_ENABLE_BIT     11
`define PW_HI        9
`define PW_LO        8
`define PWWS_HI      7
`define PWWS_LO      4
`define PRWS_HI      3
`define PRWS_LO      0
`define RRWS_HI      1
`define RRWS_LO      0
`define RWWS_HI      3
`define RWWS_LO      2
`define RBRDY_BIT    7
`define CFG1_WMASK   32'h7ef8_0bff
`define BANK_WMASK   32'h0003_c000
`define WS_RESET     4'hf
`define BANK_RESET   4'h0
`define CFG_RESET    32'h0000_0000
`define BANK_SHIFT0  5'h1c
`define BANK_BASE    5'h0d
`define DRAM_BANK    3'h4
`endif

// file: mctl_pkg.sv
// Types shared by the PROM and I/O bus configuration and error block.
package mctl_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_LEAD = 5'h02,
    S_WAIT = 5'h04,
    S_RDY  = 5'h08,
    S_DATA = 5'h10
  } bus_state_t;
  typedef enum logic [1:0] {
    AREA_PROM = 2'h0,
    AREA_IO   = 2'h1,
    AREA_RAM  = 2'h2
  } area_t;
  typedef struct packed {
    logic        write;
    area_t       area;
    logic [2:0]  bank;
    logic [27:0] addr;
    logic [31:0] wdata;
  } acc_req_t;
endpackage : mctl_pkg

// file: prom_io_bus_config_and_errors.sv
// External bus sequencer with configuration registers and bus error sampling.
`timescale 1ns/1ps
`include "mctl_params.svh"
module prom_io_bus_config_and_errors
  import mctl_pkg::*;
#(
  parameter int          BANK_SEL   = 0,
  parameter logic [3:0]  FIXED_BANK = 4'h1
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // APB register port
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  // Internal access port
  input  wire logic        REQ_VALID,
  input  wire acc_req_t    REQ,
  output logic             REQ_READY,
  output logic             RESP_DONE,
  output logic             RESP_ERROR,
  output logic      [31:0] RESP_RDATA,
  // External memory bus
  input  wire logic [1:0]  BOOT_WIDTH_INPUTS,
  input  wire logic        EXT_BUS_READY_N,
  input  wire logic        EXT_BUS_ERROR_N,
  input  wire logic [31:0] MEM_DATA_IN,
  output logic      [31:0] MEM_DATA_OUT,
  output logic      [31:0] MEM_DATA_OE,
  output logic      [31:0] SD_DATA_OE,
  output logic      [27:0] MEM_ADDR,
  output logic      [3:0]  PROM_CS_N,
  output logic             IO_CS_N,
  output logic      [4:0]  RAM_CHIP_SELECT_N,
  output logic             MEM_OE_N,
  output logic             MEM_WE_N
);

  bus_state_t  state, next_state;
  acc_req_t    cur, next_cur;
  logic [31:0] cfg1, cfg2, cfg3, cfg4;
  logic [31:0] next_cfg1, next_cfg2, next_cfg3, next_cfg4;
  logic [31:0] prdata, next_prdata;
  logic [4:0]  wcnt, next_wcnt;
  logic [1:0]  beat, next_beat;
  logic [31:0] rdata, next_rdata;
  logic        resp_done, next_resp_done;
  logic        resp_err, next_resp_err;
  logic [31:0] dout, next_dout;
  logic [31:0] doe, next_doe;
  logic [27:0] addr, next_addr;
  logic [3:0]  prom_cs_n, next_prom_cs_n;
  logic        io_cs_n, next_io_cs_n;
  logic [4:0]  ram_cs_n, next_ram_cs_n;
  logic        oe_n, next_oe_n;
  logic        we_n, next_we_n;
  // Two-stage synchronizers on every pin input; the third ready stage is
  // fed only from the second.
  logic        rdy_s1, rdy_s2, rdy_s3;
  logic        err_s1, err_s2;
  logic [1:0]  bw_s1, bw_s2;
  logic [31:0] din_s1, din_s2;
  logic        ready_seen;
  logic [1:0]  last;
  logic [4:0]  sh;

  // Data width code of the area: 0 = 8, 1 = 16, other = 32 bits.
  function automatic logic [1:0] area_width(acc_req_t r, logic [31:0] c1);
    if (r.area == AREA_PROM) begin
      area_width = c1[`PW_HI:`PW_LO];
    end else if (r.area == AREA_IO) begin
      area_width = c1[`IOW_HI:`IOW_LO];
    end else begin
      area_width = 2'h2;
    end
  endfunction : area_width

  function automatic logic [1:0] last_beat(logic [1:0] w);
    last_beat = (w == 2'h0) ? 2'h3 : ((w == 2'h1) ? 2'h1 : 2'h0);
  endfunction : last_beat

  function automatic logic [4:0] wait_count(acc_req_t r, logic [31:0] c1,
                                            logic [31:0] c2);
    if (r.area == AREA_PROM) begin
      wait_count = r.write ? {c1[`PWWS_HI:`PWWS_LO], 1'b0}
                           : {c1[`PRWS_HI:`PRWS_LO], 1'b0};
    end else if (r.area == AREA_IO) begin
      wait_count = {1'b0, c1[`IOWS_HI:`IOWS_LO]};
    end else begin
      wait_count = r.write ? {3'h0, c2[`RWWS_HI:`RWWS_LO]}
                           : {3'h0, c2[`RRWS_HI:`RRWS_LO]};
    end
  endfunction : wait_count

  function automatic logic ready_enabled(acc_req_t r, logic [31:0] c1,
                                         logic [31:0] c2);
    if (r.area == AREA_PROM) begin
      ready_enabled = c1[`PROM_READY_ENABLE_BIT];
    end else if (r.area == AREA_IO) begin
      ready_enabled = c1[`IO_READY_ENABLE_BIT];
    end else begin
      ready_enabled = c2[`RBRDY_BIT] && (r.bank == `DRAM_BANK);
    end
  endfunction : ready_enabled

  // Active-low PROM select for an address under the current bank size.
  function automatic logic [3:0] prom_select(logic [27:0] a, logic [3:0] code);
    logic [4:0]  shift;
    logic [27:0] idx;
    logic        four;
    shift = (code == 4'h0) ? `BANK_SHIFT0 : (`BANK_BASE + {1'b0, code});
    idx   = a >> shift;
    four  = (BANK_SEL == 0) && (code != 4'h0) && (code != 4'hf);
    if (!four) begin
      idx[27:1] = 27'h0;
    end else begin
      idx[27:2] = 26'h0;
    end
    prom_select = ~(4'h1 << idx[1:0]);
  endfunction : prom_select

  assign REQ_READY         = (state == S_IDLE);
  assign PRDATA            = prdata;
  assign RESP_DONE         = resp_done;
  assign RESP_ERROR        = resp_err;
  assign RESP_RDATA        = rdata;
  assign MEM_DATA_OUT      = dout;
  assign MEM_DATA_OE       = doe;
  assign SD_DATA_OE        = 32'h0000_0000;
  assign MEM_ADDR          = addr;
  assign PROM_CS_N         = prom_cs_n;
  assign IO_CS_N           = io_cs_n;
  assign RAM_CHIP_SELECT_N = ram_cs_n;
  assign MEM_OE_N          = oe_n;
  assign MEM_WE_N          = we_n;

  // Asynchronous mode asks for ready on two successive synchronized samples,
  // which filters glitches at the cost of one more cycle.
  assign ready_seen = cfg1[`ASYNC_READY_ENABLE_BIT] ? (!rdy_s2 && !rdy_s3) : !rdy_s2;

  assign last = last_beat(area_width(cur, cfg1));
  assign sh   = (area_width(cur, cfg1) == 2'h0) ? {(last - beat), 3'h0}
              : ((area_width(cur, cfg1) == 2'h1) ? {(last[0] - beat[0]), 4'h0} : 5'h00);

  always_comb begin
    logic [31:0] lane_mask;
    lane_mask      = 32'h0000_0000;
    next_state     = state;
    next_cur       = cur;
    next_cfg1      = cfg1;
    next_cfg2      = cfg2;
    next_cfg3      = cfg3;
    next_cfg4      = cfg4;
    next_prdata    = prdata;
    next_wcnt      = wcnt;
    next_beat      = beat;
    next_rdata     = rdata;
    next_resp_done = 1'b0;
    next_resp_err  = 1'b0;

    // Register port: read data is captured in the setup phase.
    if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == `CFG1_OFF) begin
        next_prdata = cfg1;
      end else if (PADDR == `CFG2_OFF) begin
        next_prdata = cfg2;
      end else if (PADDR == `CFG3_OFF) begin
        next_prdata = cfg3;
      end else if (PADDR == `CFG4_OFF) begin
        next_prdata = cfg4;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
    if (PSEL && PENABLE && PWRITE) begin
      if (PADDR == `CFG1_OFF) begin
        next_cfg1 = (cfg1 & ~`CFG1_WMASK) | (PWDATA & `CFG1_WMASK);
        if (BANK_SEL == 0) begin
          next_cfg1 = (next_cfg1 & ~`BANK_WMASK) | (PWDATA & `BANK_WMASK);
        end
      end else if (PADDR == `CFG2_OFF) begin
        next_cfg2 = PWDATA;
      end else if (PADDR == `CFG3_OFF) begin
        next_cfg3 = PWDATA;
      end else if (PADDR == `CFG4_OFF) begin
        next_cfg4 = PWDATA;
      end
    end

    case (state)
      S_IDLE: begin
        if (REQ_VALID) begin
          next_cur  = REQ;
          next_beat = 2'h0;
          // Disabled areas answer at once with an error and assert no select or strobe; address and data out still follow the request.
          if ((REQ.area == AREA_IO && !cfg1[`IO_AREA_ENABLE_BIT]) ||
              (REQ.area == AREA_PROM && REQ.write && !cfg1[`PROM_WRITE_ENABLE_BIT])) begin
            next_resp_done = 1'b1;
            next_resp_err  = 1'b1;
          end else begin
            next_state = S_LEAD;
          end
        end
      end
      S_LEAD: begin
        next_wcnt = wait_count(cur, cfg1, cfg2);
        if (next_wcnt != 5'h00) begin
          next_state = S_WAIT;
        end else if (ready_enabled(cur, cfg1, cfg2)) begin
          next_state = S_RDY;
        end else begin
          next_state = S_DATA;
        end
      end
      S_WAIT: begin
        next_wcnt = wcnt - 5'h01;
        if (wcnt == 5'h01) begin
          next_state = ready_enabled(cur, cfg1, cfg2) ? S_RDY : S_DATA;
        end
      end
      S_RDY: begin
        if (ready_seen) begin
          next_state = S_DATA;
        end
      end
      S_DATA: begin
        // Read data is taken at this edge on every beat, the error input on the last beat only;
        // after the last beat the select negates at this same edge on reads and writes.
        lane_mask = (area_width(cur, cfg1) == 2'h0) ? 32'h0000_00ff
                  : ((area_width(cur, cfg1) == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff);
        if (!cur.write) begin
          next_rdata = (rdata & ~(lane_mask << sh)) | ((din_s2 & lane_mask) << sh);
        end
        if (beat == last) begin
          next_state     = S_IDLE;
          next_resp_done = 1'b1;
          next_resp_err  = cfg1[`BEXC_BIT] && !err_s2;
        end else begin
          next_beat  = beat + 2'h1;
          next_state = S_LEAD;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Pin drive follows the next state so that pins change with the state.
  always_comb begin
    logic active;
    logic [1:0] w;
    logic [1:0] lb;
    logic [4:0] nsh;
    active         = (next_state != S_IDLE);
    w              = area_width(next_cur, next_cfg1);
    lb             = last_beat(w);
    nsh            = (w == 2'h0) ? {(lb - next_beat), 3'h0}
                   : ((w == 2'h1) ? {(lb[0] - next_beat[0]), 4'h0} : 5'h00);
    next_addr      = next_cur.addr + {26'h0, next_beat};
    next_dout      = next_cur.wdata >> nsh;
    next_doe       = (active && next_cur.write) ? 32'hffff_ffff : 32'h0000_0000;
    next_oe_n      = !(active && !next_cur.write);
    next_we_n      = !(active && next_cur.write && next_state != S_LEAD);
    next_prom_cs_n = 4'hf;
    next_io_cs_n   = 1'b1;
    next_ram_cs_n  = 5'h1f;
    if (active && next_cur.area == AREA_PROM) begin
      next_prom_cs_n = prom_select(next_cur.addr, next_cfg1[`BANK_HI:`BANK_LO]);
    end else if (active && next_cur.area == AREA_IO) begin
      next_io_cs_n = 1'b0;
    end else if (active) begin
      next_ram_cs_n = ~(5'h01 << next_cur.bank);
    end
  end

  always_ff @(posedge CLOCK) begin
    rdy_s1 <= EXT_BUS_READY_N;
    rdy_s2 <= rdy_s1;
    rdy_s3 <= rdy_s2;
    err_s1 <= EXT_BUS_ERROR_N;
    err_s2 <= err_s1;
    bw_s1  <= BOOT_WIDTH_INPUTS;
    bw_s2  <= bw_s1;
    din_s1 <= MEM_DATA_IN;
    din_s2 <= din_s1;
    if (!RST_N) begin
      state     <= S_IDLE;
      cur       <= '0;
      // boot width loaded, PROM read and write waits at maximum, enables cleared.
      cfg1      <= `CFG_RESET;
      cfg1[`PW_HI:`PW_LO]     <= bw_s2;
      cfg1[`PWWS_HI:`PWWS_LO] <= `WS_RESET;
      cfg1[`PRWS_HI:`PRWS_LO] <= `WS_RESET;
      cfg1[`BANK_HI:`BANK_LO] <= (BANK_SEL == 0) ? `BANK_RESET : FIXED_BANK;
      cfg2      <= `CFG_RESET;
      cfg3      <= `CFG_RESET;
      cfg4      <= `CFG_RESET;
      prdata    <= 32'h0000_0000;
      wcnt      <= 5'h00;
      beat      <= 2'h0;
      rdata     <= 32'h0000_0000;
      resp_done <= 1'b0;
      resp_err  <= 1'b0;
      dout      <= 32'h0000_0000;
      doe       <= 32'h0000_0000;
      addr      <= 28'h000_0000;
      prom_cs_n <= 4'hf;
      io_cs_n   <= 1'b1;
      ram_cs_n  <= 5'h1f;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      cfg1      <= next_cfg1;
      cfg2      <= next_cfg2;
      cfg3      <= next_cfg3;
      cfg4      <= next_cfg4;
      prdata    <= next_prdata;
      wcnt      <= next_wcnt;
      beat      <= next_beat;
      rdata     <= next_rdata;
      resp_done <= next_resp_done;
      resp_err  <= next_resp_err;
      dout      <= next_dout;
      doe       <= next_doe;
      addr      <= next_addr;
      prom_cs_n <= next_prom_cs_n;
      io_cs_n   <= next_io_cs_n;
      ram_cs_n  <= next_ram_cs_n;
      oe_n      <= next_oe_n;
      we_n      <= next_we_n;
    end
  end

endmodule : prom_io_bus_config_and_errors

// file: prom_io_bus_chk.sv
// Port checker for the external bus sequencer and its error response.
`timescale 1ns/1ps
module prom_io_bus_chk
  import mctl_pkg::*;
(
  // Clock, reset and register port
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  // Access port
  input wire logic        REQ_VALID,
  input wire acc_req_t    REQ,
  input wire logic        REQ_READY,
  input wire logic        RESP_DONE,
  input wire logic        RESP_ERROR,
  // Memory pins
  input wire logic [31:0] MEM_DATA_OE,
  input wire logic [31:0] SD_DATA_OE,
  input wire logic [3:0]  PROM_CS_N,
  input wire logic        IO_CS_N,
  input wire logic [4:0]  RAM_CHIP_SELECT_N,
  input wire logic        MEM_OE_N,
  input wire logic        MEM_WE_N
);
  logic  bexc;
  logic  io_area_enable;
  logic  prom_write_enable;
  logic  w;
  area_t ar;
  // Shadow of the enable bits, so refusals can be tied to what software wrote.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      bexc <= 1'b0;
      io_area_enable <= 1'b0;
      prom_write_enable <= 1'b0;
    end else if (PSEL && PENABLE && PWRITE && PADDR == 8'h00) begin
      bexc <= PWDATA[25];
      io_area_enable <= PWDATA[19];
      prom_write_enable <= PWDATA[11];
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      w  <= 1'b0;
      ar <= AREA_PROM;
    end else if (REQ_VALID && REQ_READY) begin
      w  <= REQ.write;
      ar <= REQ.area;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_sd_oe_zero: assert property (SD_DATA_OE == 32'h0)
    else $error("SDRAM drive vector not zero");
  a_read_no_drive: assert property (!MEM_OE_N |-> MEM_DATA_OE == 32'h0)
    else $error("data driven during read");
  a_write_drive: assert property (!MEM_WE_N |-> MEM_DATA_OE == 32'hffff_ffff)
    else $error("data not driven during write");
  a_done_pulse: assert property (RESP_DONE |-> REQ_READY ##1 !RESP_DONE)
    else $error("done not a single pulse");
  a_err_with_done: assert property (RESP_ERROR |-> RESP_DONE)
    else $error("error outside done");
  a_strobe_excl: assert property (!(!MEM_OE_N && !MEM_WE_N))
    else $error("read and write strobes together");
  a_prom_one_cs: assert property ($onehot0(~PROM_CS_N))
    else $error("several PROM selects");
  a_idle_no_pins: assert property (REQ_READY |-> &PROM_CS_N && IO_CS_N && &RAM_CHIP_SELECT_N)
    else $error("select active while idle");
  a_err_cause: assert property (RESP_DONE && RESP_ERROR |->
      bexc || (ar == AREA_IO && !io_area_enable) || (ar == AREA_PROM && w && !prom_write_enable))
    else $error("error response without cause");
  a_io_refused: assert property (RESP_DONE && ar == AREA_IO && !io_area_enable |-> RESP_ERROR)
    else $error("disabled I/O access not refused");
  a_prom_wr_gate: assert property (!MEM_WE_N && !(&PROM_CS_N) |-> prom_write_enable)
    else $error("PROM write with writes disabled");
endmodule : prom_io_bus_chk
bind prom_io_bus_config_and_errors prom_io_bus_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .RESP_DONE(RESP_DONE),
  .RESP_ERROR(RESP_ERROR), .MEM_DATA_OE(MEM_DATA_OE), .SD_DATA_OE(SD_DATA_OE),
  .PROM_CS_N(PROM_CS_N), .IO_CS_N(IO_CS_N), .RAM_CHIP_SELECT_N(RAM_CHIP_SELECT_N),
  .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N));

// file: ext_mem_model.sv
// Behavioural PROM and I/O device answering the sequencer pins.
`timescale 1ns/1ps
module ext_mem_model (
  // Sequencer pins
  input  wire logic        CLOCK,
  input  wire logic [27:0] MEM_ADDR,
  input  wire logic [3:0]  PROM_CS_N,
  input  wire logic        IO_CS_N,
  input  wire logic        MEM_OE_N,
  input  wire logic        DRAM_CS_N,
  output logic      [31:0] MEM_DATA_IN,
  output logic             EXT_BUS_READY_N,
  output logic             EXT_BUS_ERROR_N,
  // Fault control
  input  wire logic        ERR_ON,
  input  wire logic [1:0]  ERR_BEAT,
  // Ready lag in cycles after select
  input  wire logic [3:0]  RDY_LAG
);
  logic        sel;
  logic [31:0] last = 32'h0;
  logic [3:0]  held = 4'h0;
  assign sel = !(&PROM_CS_N) || !IO_CS_N || !DRAM_CS_N;
  // Counts selected cycles so ready can be held off to stretch an access.
  always_ff @(posedge CLOCK) begin
    if (!sel) begin
      held <= 4'h0;
    end else if (held != 4'hf) begin
      held <= held + 4'h1;
    end
  end
  // A released bus shows the inverse of the last value, so stale data cannot pass.
  assign MEM_DATA_IN = (sel && !MEM_OE_N) ? {4{MEM_ADDR[7:0]}} : ~last;
  always_ff @(posedge CLOCK) begin
    if (sel && !MEM_OE_N) begin
      last <= MEM_DATA_IN;
    end
  end
  assign EXT_BUS_READY_N = !(sel && held >= RDY_LAG);
  assign EXT_BUS_ERROR_N = !(ERR_ON && sel && MEM_ADDR[1:0] == ERR_BEAT);
endmodule : ext_mem_model

// file: test_prom_io_bus_config_and_errors.sv
// Directed test of the external bus sequencer and its configuration registers.
`timescale 1ns/1ps
module test_prom_io_bus_config_and_errors
  import mctl_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic req_valid = 1'b0, err_on = 1'b0, req_ready, resp_done, resp_error, io_cs_n;
  logic mem_oe_n, mem_we_n, ready_n, error_n, err, we_seen;
  logic [1:0] err_beat = 2'h0, boot_w = 2'h2;
  logic [2:0] bank = 3'h0;
  logic [3:0] prom_cs_n, cs_seen, rdy_lag = 4'h0;
  logic [4:0] ram_cs_n;
  logic [7:0] paddr = 8'h0;
  logic [27:0] mem_addr;
  logic [31:0] pwdata = 32'h0, prdata, resp_rdata, mem_din, mem_dout, mem_oe, sd_oe;
  logic [31:0] rdat, dout, q;
  acc_req_t req = '0;
  int n, n0, n_fail = 0, checked = 0, cycles = 0;
  localparam logic [31:0] WD = 32'hc3a5_9610;
  always #2.5 clock = ~clock;
  prom_io_bus_config_and_errors #(.BANK_SEL(0)) dut_u (.CLOCK(clock), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .RESP_DONE(resp_done), .RESP_ERROR(resp_error), .RESP_RDATA(resp_rdata),
    .BOOT_WIDTH_INPUTS(boot_w), .EXT_BUS_READY_N(ready_n), .EXT_BUS_ERROR_N(error_n),
    .MEM_DATA_IN(mem_din), .MEM_DATA_OUT(mem_dout), .MEM_DATA_OE(mem_oe),
    .SD_DATA_OE(sd_oe), .MEM_ADDR(mem_addr), .PROM_CS_N(prom_cs_n), .IO_CS_N(io_cs_n),
    .RAM_CHIP_SELECT_N(ram_cs_n), .MEM_OE_N(mem_oe_n), .MEM_WE_N(mem_we_n));
  ext_mem_model mem_u (.CLOCK(clock), .MEM_ADDR(mem_addr), .PROM_CS_N(prom_cs_n),
    .IO_CS_N(io_cs_n), .MEM_OE_N(mem_oe_n), .DRAM_CS_N(ram_cs_n[4]), .MEM_DATA_IN(mem_din),
    .EXT_BUS_READY_N(ready_n), .EXT_BUS_ERROR_N(error_n), .ERR_ON(err_on),
    .ERR_BEAT(err_beat), .RDY_LAG(rdy_lag));
  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    q = prdata;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q, e);
  endtask : rchk
  // One request; n counts edges from acceptance to the done pulse.
  task automatic acc(input logic w, input area_t ar, input logic [27:0] a, output int n);
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{w, ar, bank, a, WD};
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    cs_seen = 4'h0;
    we_seen = 1'b0;
    while (n < 200) begin
      #1;
      n++;
      cs_seen = cs_seen | ~prom_cs_n;
      we_seen = we_seen | !mem_we_n;
      if (!mem_we_n) dout = mem_dout;
      if (resp_done === 1'b1) break;
      @(posedge clock);
    end
    err = resp_error;
    rdat = resp_rdata;
  endtask : acc
  function automatic logic [31:0] cfg(input logic [3:0] rws, wws, iows, input logic [1:0] pw,
                                      input logic bx, en);
    return {3'h0, pw, 1'b0, bx, 1'b0, iows, en, 7'h0, en, 1'b0, pw, wws, rws};
  endfunction : cfg
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0000_02ff);
    rchk(8'h04, 32'h0);
    rchk(8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rchk(8'h00, 32'h7efb_cbff);
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, 8'(4 * i), 32'h5a00_0000 | 32'(i));
      rchk(8'(4 * i), 32'h5a00_0000 | 32'(i));
    end
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h00, 32'(c) << 14);
      rchk(8'h00, 32'(c) << 14);
    end
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 8'h00, cfg(4'h1, 4'h1, 4'h0, 2'h2, 1'b0, 1'b1) | (32'(c) << 14));
      acc(1'b0, AREA_PROM, 28'hc000, n);
      check({28'h0, cs_seen}, (c == 1) ? 32'h8 : 32'h1);
    end
    apb(1'b1, 8'h00, cfg(4'h1, 4'h1, 4'h0, 2'h2, 1'b1, 1'b1));
    acc(1'b0, AREA_PROM, 28'h34, n0);
    check(rdat, 32'h3434_3434);
    check({31'h0, err}, 32'h0);
    acc(1'b1, AREA_PROM, 28'h40, n);
    check(dout, WD);
    acc(1'b0, AREA_IO, 28'h40, n0);
    apb(1'b1, 8'h00, cfg(4'h3, 4'h3, 4'h5, 2'h2, 1'b1, 1'b1));
    acc(1'b0, AREA_IO, 28'h40, n);
    check(32'(n - n0), 32'h5);
    acc(1'b1, AREA_PROM, 28'h40, n0);
    apb(1'b1, 8'h00, cfg(4'h3, 4'h1, 4'h5, 2'h2, 1'b1, 1'b1));
    acc(1'b1, AREA_PROM, 28'h40, n);
    check(32'(n0 - n), 32'h4);
    acc(1'b0, AREA_PROM, 28'h34, n0);
    apb(1'b1, 8'h00, cfg(4'h1, 4'h1, 4'h5, 2'h2, 1'b1, 1'b1));
    acc(1'b0, AREA_PROM, 28'h34, n);
    check(32'(n0 - n), 32'h4);
    err_on <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 8'h00, cfg(4'h1, 4'h1, 4'h2, 2'h2, b[0], 1'b1));
      acc(1'b0, AREA_PROM, 28'h50, n);
      check({31'h0, err}, 32'(b));
      acc(1'b1, AREA_PROM, 28'h50, n);
      check({31'h0, err}, 32'(b));
      acc(1'b0, AREA_IO, 28'h50, n);
      check({31'h0, err}, 32'(b));
    end
    apb(1'b1, 8'h00, cfg(4'h1, 4'h1, 4'h2, 2'h0, 1'b1, 1'b1));
    for (int b = 0; b < 4; b += 3) begin
      err_beat <= 2'(b);
      acc(1'b0, AREA_PROM, 28'h10, n);
      check(rdat, 32'h1011_1213);
      check({31'h0, err}, (b == 3) ? 32'h1 : 32'h0);
      acc(1'b0, AREA_IO, 28'h10, n);
      check(rdat, 32'h1011_1213);
    end
    err_on <= 1'b0;
    apb(1'b1, 8'h00, cfg(4'h1, 4'h1, 4'h0, 2'h2, 1'b0, 1'b0));
    acc(1'b0, AREA_IO, 28'h0, n);
    check({31'h0, err}, 32'h1);
    acc(1'b1, AREA_PROM, 28'h0, n);
    check({30'h0, err, we_seen}, 32'h2);
    acc(1'b0, AREA_PROM, 28'h34, n);
    check({31'h0, err}, 32'h0);
    // Ready stretching: no waits, so every count is lead, sync delay and data.
    apb(1'b1, 8'h04, 32'h0000_0080);
    apb(1'b1, 8'h00, cfg(4'h0, 4'h1, 4'h0, 2'h2, 1'b0, 1'b1) | 32'h4400_0000);
    acc(1'b0, AREA_PROM, 28'h34, n);
    check(32'(n), 32'h5);
    rdy_lag <= 4'h3;
    acc(1'b0, AREA_PROM, 28'h34, n);
    check(32'(n), 32'h8);
    check(rdat, 32'h3434_3434);
    acc(1'b0, AREA_IO, 28'h34, n);
    check(32'(n), 32'h8);
    bank <= 3'h4;
    acc(1'b0, AREA_RAM, 28'h34, n);
    check(32'(n), 32'h8);
    bank <= 3'h0;
    apb(1'b1, 8'h00, cfg(4'h0, 4'h1, 4'h0, 2'h2, 1'b0, 1'b1) | 32'h6400_0000);
    acc(1'b0, AREA_PROM, 28'h34, n);
    check(32'(n), 32'h9);
    // A second reset picks up a changed boot width.
    @(posedge clock);
    rst_n <= 1'b0;
    boot_w <= 2'h1;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0000_01ff);
    stop_test();
  end
endmodule : test_prom_io_bus_config_and_errors
